//--- rtl/udsir_defs.vh
`ifndef UDSIR_DEFS_VH
`define UDSIR_DEFS_VH

`define UDSIR_OFS_FRAME      8'h00
`define UDSIR_OFS_GLOBAL     8'h04
`define UDSIR_OFS_FUNC_ADDR  8'h08
`define UDSIR_OFS_MASK_SET   8'h10
`define UDSIR_OFS_MASK_CLR   8'h14
`define UDSIR_OFS_MASK       8'h18

`define UDSIR_FRAME_BAD_BIT  16
`define UDSIR_FRAME_GOOD_BIT 17

`define UDSIR_GLB_ADDR_BIT   0
`define UDSIR_GLB_CFG_BIT    1
`define UDSIR_GLB_SEND_BIT   2
`define UDSIR_GLB_RSM_BIT    3
`define UDSIR_GLB_RWE_BIT    4

`define UDSIR_FUNC_EN_BIT    8
`define UDSIR_FUNC_EN_RESET  1'b1
`define UDSIR_FUNC_ADDR_RST  7'h00

`define UDSIR_MASK_WRITABLE  16'h2BFF
`define UDSIR_MASK_FIXED     16'h1000
`define UDSIR_MASK_RESET     16'h1200

`define UDSIR_RESP_OKAY      2'h0
`define UDSIR_RESP_SLVERR    2'h2

`endif

//--- rtl/udsir_axil_slave.v
`timescale 1ns/1ps
`include "udsir_defs.vh"
module udsir_axil_slave #(
   parameter ADDR_W = 8
) (
   // clock and reset
   input  wire              clock,
   input  wire              rst,
   // write channels
   input  wire [ADDR_W-1:0] s_awaddr,
   input  wire              s_awvalid,
   output reg               s_awready,
   input  wire [31:0]       s_wdata,
   input  wire [3:0]        s_wstrb,
   input  wire              s_wvalid,
   output reg               s_wready,
   output reg  [1:0]        s_bresp,
   output reg               s_bvalid,
   input  wire              s_bready,
   // read channels
   input  wire [ADDR_W-1:0] s_araddr,
   input  wire              s_arvalid,
   output reg               s_arready,
   output reg  [31:0]       s_rdata,
   output reg  [1:0]        s_rresp,
   output reg               s_rvalid,
   input  wire              s_rready,
   // register side
   output wire              wr_go,
   output reg  [ADDR_W-1:0] wr_addr,
   output reg  [31:0]       wr_data,
   output reg  [3:0]        wr_strb,
   input  wire              wr_err,
   output wire [ADDR_W-1:0] rd_addr,
   input  wire [31:0]       rd_data,
   input  wire              rd_err
);
   reg aw_have_q;
   reg w_have_q;

   // address and data may arrive in either order; both are held until the write fires
   assign wr_go   = aw_have_q & w_have_q & ~s_bvalid;
   assign rd_addr = s_araddr;

   always @(posedge clock) begin
      if (rst) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         s_awready <= 1'b1;
         s_wready  <= 1'b1;
         s_bvalid  <= 1'b0;
         s_bresp   <= `UDSIR_RESP_OKAY;
         wr_addr   <= {ADDR_W{1'b0}};
         wr_data   <= 32'h00000000;
         wr_strb   <= 4'h0;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_have_q <= 1'b1;
            wr_addr   <= s_awaddr;
            s_awready <= 1'b0;
         end
         if (s_wvalid && s_wready) begin
            w_have_q <= 1'b1;
            wr_data  <= s_wdata;
            wr_strb  <= s_wstrb;
            s_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            s_bvalid  <= 1'b1;
            s_bresp   <= wr_err ? `UDSIR_RESP_SLVERR : `UDSIR_RESP_OKAY;
         end
         if (s_bvalid && s_bready) begin
            s_bvalid  <= 1'b0;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
         end
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         s_arready <= 1'b1;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h00000000;
         s_rresp   <= `UDSIR_RESP_OKAY;
      end else begin
         if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rdata   <= rd_data;
            s_rresp   <= rd_err ? `UDSIR_RESP_SLVERR : `UDSIR_RESP_OKAY;
         end
         if (s_rvalid && s_rready) begin
            s_rvalid  <= 1'b0;
            s_arready <= 1'b1;
         end
      end
   end
endmodule // udsir_axil_slave

//--- rtl/udsir_top.v
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "udsir_defs.vh"
module udsir_top #(
   parameter ADDR_W = 8
) (
   // clock and reset
   input  wire              clock,
   input  wire              rst,
   // axi4-lite register bus
   input  wire [ADDR_W-1:0] s_awaddr,
   input  wire              s_awvalid,
   output wire              s_awready,
   input  wire [31:0]       s_wdata,
   input  wire [3:0]        s_wstrb,
   input  wire              s_wvalid,
   output wire              s_wready,
   output wire [1:0]        s_bresp,
   output wire              s_bvalid,
   input  wire              s_bready,
   input  wire [ADDR_W-1:0] s_araddr,
   input  wire              s_arvalid,
   output wire              s_arready,
   output wire [31:0]       s_rdata,
   output wire [1:0]        s_rresp,
   output wire              s_rvalid,
   input  wire              s_rready,
   // packet decoder events, same clock
   input  wire              sof_packet_id,
   input  wire              sof_packet_end,
   input  wire              sof_crc_bad,
   input  wire [10:0]       sof_frame_in,
   input  wire              host_resume,
   input  wire              usb_bus_reset,
   // interrupt status from the status register block
   input  wire [15:0]       interrupt_status,
   // device state towards the link logic
   output reg               address_state_bit,
   output reg               configured_state_bit,
   output reg  [6:0]        function_address_value,
   output reg               function_enable_bit,
   output reg               remote_wake_start,
   output reg               start_of_frame_irq,
   output reg               irq
);
   // bus side
   wire              wr_go;
   wire [ADDR_W-1:0] wr_addr;
   wire [31:0]       wr_data;
   wire [3:0]        wr_strb;
   wire [ADDR_W-1:0] rd_addr;
   reg  [31:0]       rd_data;
   reg               rd_err;
   reg               wr_err;

   // frame number register
   reg  [10:0]       frame_index_q;
   reg               frame_bad_flag_q;
   reg               frame_good_flag_q;

   // global state register
   reg               send_resume_bit_q;
   reg               resume_seen_bit_q;
   reg               remote_wake_enable_q;

   // interrupt mask, only the writable bits are stored
   reg  [15:0]       mask_q;
   wire [15:0]       mask_read;

   // decoded write strobes
   wire              wr_global;
   wire              wr_func_addr;
   wire              wr_mset;
   wire              wr_mclr;
   wire [31:0]       wr_lanes;
   wire [31:0]       wr_bits;
   wire              send_write_one;
   wire              send_write_zero;
   wire              rwe_next;
   wire              resume_hit;
   wire              irq_any;

   // the slave holds address and data from capture until the response is taken
   udsir_axil_slave #(
      .ADDR_W (ADDR_W)
   ) u_bus (
      .clock     (clock),
      .rst       (rst),
      .s_awaddr  (s_awaddr),
      .s_awvalid (s_awvalid),
      .s_awready (s_awready),
      .s_wdata   (s_wdata),
      .s_wstrb   (s_wstrb),
      .s_wvalid  (s_wvalid),
      .s_wready  (s_wready),
      .s_bresp   (s_bresp),
      .s_bvalid  (s_bvalid),
      .s_bready  (s_bready),
      .s_araddr  (s_araddr),
      .s_arvalid (s_arvalid),
      .s_arready (s_arready),
      .s_rdata   (s_rdata),
      .s_rresp   (s_rresp),
      .s_rvalid  (s_rvalid),
      .s_rready  (s_rready),
      .wr_go     (wr_go),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data),
      .wr_strb   (wr_strb),
      .wr_err    (wr_err),
      .rd_addr   (rd_addr),
      .rd_data   (rd_data),
      .rd_err    (rd_err)
   );

   // byte lanes without a strobe write nothing
   assign wr_lanes = {{8{wr_strb[3]}},
                      {8{wr_strb[2]}},
                      {8{wr_strb[1]}},
                      {8{wr_strb[0]}}};
   assign wr_bits  = wr_data & wr_lanes;

   assign wr_global    = wr_go && (wr_addr == `UDSIR_OFS_GLOBAL);
   assign wr_func_addr = wr_go && (wr_addr == `UDSIR_OFS_FUNC_ADDR);
   assign wr_mset      = wr_go && (wr_addr == `UDSIR_OFS_MASK_SET);
   assign wr_mclr      = wr_go && (wr_addr == `UDSIR_OFS_MASK_CLR);

   // the state bits of the global register all sit in byte lane 0
   assign send_write_one  = wr_global && wr_strb[0] && wr_data[`UDSIR_GLB_SEND_BIT];
   assign send_write_zero = wr_global && wr_strb[0] && !wr_data[`UDSIR_GLB_SEND_BIT];
   // an enable written together with the send bit already counts for that write
   assign rwe_next        = (wr_global && wr_strb[0]) ? wr_data[`UDSIR_GLB_RWE_BIT]
                                                      : remote_wake_enable_q;
   assign resume_hit      = host_resume && send_resume_bit_q && remote_wake_enable_q;

   // bit 12 cannot be masked
   assign mask_read = mask_q | `UDSIR_MASK_FIXED;
   assign irq_any   = |(interrupt_status & mask_read);

   // write side: the frame register is read-only, so a write there is refused
   // the mask read word and unmapped words refuse a write the same way
   always @* begin
      case (wr_addr)
         `UDSIR_OFS_GLOBAL:    wr_err = 1'b0;
         `UDSIR_OFS_FUNC_ADDR: wr_err = 1'b0;
         `UDSIR_OFS_MASK_SET:  wr_err = 1'b0;
         `UDSIR_OFS_MASK_CLR:  wr_err = 1'b0;
         default:              wr_err = 1'b1;
      endcase
   end

   // read side: the write-only ports read as zero
   // reads have no side effect, so the mux follows the live s_araddr from the bus
   always @* begin
      rd_data = 32'h00000000;
      rd_err  = 1'b0;
      case (rd_addr)
         `UDSIR_OFS_FRAME: begin
            rd_data[10:0]                  = frame_index_q;
            rd_data[`UDSIR_FRAME_BAD_BIT]  = frame_bad_flag_q;
            rd_data[`UDSIR_FRAME_GOOD_BIT] = frame_good_flag_q;
         end
         `UDSIR_OFS_GLOBAL: begin
            rd_data[`UDSIR_GLB_ADDR_BIT] = address_state_bit;
            rd_data[`UDSIR_GLB_CFG_BIT]  = configured_state_bit;
            rd_data[`UDSIR_GLB_SEND_BIT] = send_resume_bit_q;
            rd_data[`UDSIR_GLB_RSM_BIT]  = resume_seen_bit_q;
            rd_data[`UDSIR_GLB_RWE_BIT]  = remote_wake_enable_q;
         end
         `UDSIR_OFS_FUNC_ADDR: begin
            rd_data[6:0]                = function_address_value;
            rd_data[`UDSIR_FUNC_EN_BIT] = function_enable_bit;
         end
         `UDSIR_OFS_MASK_SET: begin
            rd_data = 32'h00000000;
         end
         `UDSIR_OFS_MASK_CLR: begin
            rd_data = 32'h00000000;
         end
         `UDSIR_OFS_MASK: begin
            rd_data[15:0] = mask_read;
         end
         default: begin
            rd_err = 1'b1;
         end
      endcase
   end

   // frame number and frame status
   // a bad packet still updates the index, so software sees which frame failed
   always @(posedge clock) begin
      if (rst) begin
         frame_index_q     <= 11'h000;
         frame_bad_flag_q  <= 1'b0;
         frame_good_flag_q <= 1'b0;
      end else begin
         if (sof_packet_id) begin
            frame_bad_flag_q  <= 1'b0;
            frame_good_flag_q <= 1'b0;
         end
         // the end of packet follows its id, so the set here lands last
         if (sof_packet_end) begin
            frame_index_q <= sof_frame_in;
            if (sof_crc_bad) begin
               frame_bad_flag_q <= 1'b1;
            end else begin
               frame_good_flag_q <= 1'b1;
            end
         end
      end
   end

   // sof interrupt event goes out on the pid, long before the end of packet
   always @(posedge clock) begin
      if (rst) begin
         start_of_frame_irq <= 1'b0;
      end else begin
         start_of_frame_irq <= sof_packet_id;
      end
   end

   // device state; a usb bus reset returns it to default state
   // configured just follows the write; keeping it to address state is up to software
   always @(posedge clock) begin
      if (rst || usb_bus_reset) begin
         address_state_bit    <= 1'b0;
         configured_state_bit <= 1'b0;
      end else if (wr_global && wr_strb[0]) begin
         if (wr_data[`UDSIR_GLB_ADDR_BIT]) begin
            address_state_bit <= 1'b1;
         end
         configured_state_bit <= wr_data[`UDSIR_GLB_CFG_BIT];
      end
   end

   // remote wake-up
   // the start is a one-cycle pulse; the link logic times the resume signalling
   always @(posedge clock) begin
      if (rst || usb_bus_reset) begin
         send_resume_bit_q    <= 1'b0;
         remote_wake_enable_q <= 1'b0;
         remote_wake_start    <= 1'b0;
      end else begin
         remote_wake_start <= 1'b0;
         if (wr_global && wr_strb[0]) begin
            send_resume_bit_q    <= wr_data[`UDSIR_GLB_SEND_BIT];
            remote_wake_enable_q <= wr_data[`UDSIR_GLB_RWE_BIT];
         end
         // only a rising write starts the procedure; holding 1 does not restart it
         if (send_write_one && !send_resume_bit_q && rwe_next) begin
            remote_wake_start <= 1'b1;
         end
      end
   end

   // resume seen: set wins over the clear in the same cycle
   // dropping the send bit or the enable ends the wake-up, so the flag drops too
   always @(posedge clock) begin
      if (rst || usb_bus_reset) begin
         resume_seen_bit_q <= 1'b0;
      end else if (resume_hit) begin
         resume_seen_bit_q <= 1'b1;
      end else if (send_write_zero || !rwe_next) begin
         resume_seen_bit_q <= 1'b0;
      end
   end

   // function address and enable; the bus reset leaves the enable to software
   // address and enable sit in different byte lanes and are written independently
   // the host-side reset wins over a write of the address in the same cycle
   always @(posedge clock) begin
      if (rst) begin
         function_address_value <= `UDSIR_FUNC_ADDR_RST;
         function_enable_bit    <= `UDSIR_FUNC_EN_RESET;
      end else begin
         if (usb_bus_reset) begin
            function_address_value <= `UDSIR_FUNC_ADDR_RST;
         end else if (wr_func_addr && wr_strb[0]) begin
            function_address_value <= wr_data[6:0];
         end
         if (wr_func_addr && wr_strb[1]) begin
            function_enable_bit <= wr_data[`UDSIR_FUNC_EN_BIT];
         end
      end
   end

   // interrupt mask; the bus reset reloads it, so the resume mask stays on
   // the fixed bit is never stored, so no write can drop it
   always @(posedge clock) begin
      if (rst || usb_bus_reset) begin
         mask_q <= `UDSIR_MASK_RESET & `UDSIR_MASK_WRITABLE;
      end else if (wr_mset) begin
         mask_q <= mask_q | (wr_bits[15:0] & `UDSIR_MASK_WRITABLE);
      end else if (wr_mclr) begin
         mask_q <= mask_q & ~(wr_bits[15:0] & `UDSIR_MASK_WRITABLE);
      end
   end

   // interrupt request, registered so it never glitches; it lags the status a cycle
   always @(posedge clock) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_any;
      end
   end
endmodule // udsir_top

//--- dv/udsir_props.sv
`timescale 1ns/1ps
module udsir_props (
   // clock and reset
   input wire        clock,
   input wire        rst,
   // events and state
   input wire        sof_packet_id,
   input wire        usb_bus_reset,
   input wire [15:0] interrupt_status,
   input wire        address_state_bit,
   input wire        configured_state_bit,
   input wire [6:0]  function_address_value,
   input wire        function_enable_bit,
   input wire        remote_wake_start,
   input wire        start_of_frame_irq,
   input wire        irq
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // the pid alone raises it, the end of packet is not awaited
   a_sof_irq_pulse: assert property (
      sof_packet_id |=> start_of_frame_irq ##1 !start_of_frame_irq)
      else $error("sof irq not one pulse after pid");
   a_sof_irq_cause: assert property (
      start_of_frame_irq |-> $past(sof_packet_id))
      else $error("sof irq without pid");
   a_irq_fixed_bit: assert property (
      interrupt_status[12] |=> irq)
      else $error("bus reset end status not forwarded");
   a_irq_no_cause: assert property (
      irq |-> $past(interrupt_status) != 16'h0000)
      else $error("irq with no status");
   a_bus_reset_clears: assert property (
      usb_bus_reset |=> !address_state_bit && !configured_state_bit
                        && function_address_value == 7'h00)
      else $error("bus reset left device state");
   a_addr_state_sticky: assert property (
      $fell(address_state_bit) |-> $past(usb_bus_reset))
      else $error("address state left without reset");
   a_reset_defaults: assert property (
      $fell(rst) |-> function_enable_bit && function_address_value == 7'h00
                     && !address_state_bit)
      else $error("wrong state after reset");
   a_wake_one_cycle: assert property (
      remote_wake_start |=> !remote_wake_start)
      else $error("wake start longer than a cycle");

   c_sof: cover property (start_of_frame_irq);
   c_irq: cover property (irq);
   c_wake: cover property (remote_wake_start);
   c_bus_reset: cover property (usb_bus_reset ##1 !address_state_bit);
endmodule // udsir_props

bind udsir_top udsir_props u_props (
   .clock(clock), .rst(rst), .sof_packet_id(sof_packet_id),
   .usb_bus_reset(usb_bus_reset), .interrupt_status(interrupt_status),
   .address_state_bit(address_state_bit), .configured_state_bit(configured_state_bit),
   .function_address_value(function_address_value),
   .function_enable_bit(function_enable_bit), .remote_wake_start(remote_wake_start),
   .start_of_frame_irq(start_of_frame_irq), .irq(irq));

//--- dv/udsir_host_model.sv
`timescale 1ns/1ps
module udsir_host_model (
   // clock
   input  wire        clock,
   // decoded bus events
   output reg         sof_packet_id,
   output reg         sof_packet_end,
   output reg         sof_crc_bad,
   output reg  [10:0] sof_frame_in,
   output reg         host_resume,
   output reg         usb_bus_reset
);
   initial begin
      sof_packet_id = 1'b0;
      sof_packet_end = 1'b0;
      sof_crc_bad = 1'b1;
      sof_frame_in = 11'h555;
      host_resume = 1'b0;
      usb_bus_reset = 1'b0;
   end

   // pid first, then the frame fields some cycles later with the end pulse
   task automatic sof(input [10:0] f, input bad, input integer gap);
      begin
         sof_packet_id <= 1'b1;
         @(posedge clock);
         sof_packet_id <= 1'b0;
         repeat (gap) @(posedge clock);
         sof_frame_in <= f;
         sof_crc_bad <= bad;
         sof_packet_end <= 1'b1;
         @(posedge clock);
         sof_packet_end <= 1'b0;
         // fields are stale outside the end pulse, so never leave them valid
         sof_frame_in <= ~f;
         sof_crc_bad <= ~bad;
      end
   endtask

   task automatic pulse(input is_reset);
      begin
         if (is_reset) usb_bus_reset <= 1'b1;
         else host_resume <= 1'b1;
         @(posedge clock);
         usb_bus_reset <= 1'b0;
         host_resume <= 1'b0;
      end
   endtask
endmodule // udsir_host_model

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   reg         clock = 1'b0;
   reg         rst = 1'b1;
   reg  [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
   reg  [31:0] s_wdata = 32'h0;
   reg  [3:0]  s_wstrb = 4'hF;
   reg         s_awvalid = 1'b0, s_wvalid = 1'b0, s_arvalid = 1'b0;
   reg         s_bready = 1'b1, s_rready = 1'b1;
   reg  [15:0] interrupt_status = 16'h0000;
   wire        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   wire [1:0]  s_bresp, s_rresp;
   wire [31:0] s_rdata;
   wire        sof_packet_id, sof_packet_end, sof_crc_bad, host_resume, usb_bus_reset;
   wire [10:0] sof_frame_in;
   wire        address_state_bit, configured_state_bit, function_enable_bit;
   wire        remote_wake_start, start_of_frame_irq, irq;
   wire [6:0]  function_address_value;
   integer     fail_count = 0, comparisons = 0, wakes = 0, cycles = 0;

   always #10 clock = ~clock;

   udsir_top DUT (.clock(clock), .rst(rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
      .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
      .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
      .sof_packet_id(sof_packet_id), .sof_packet_end(sof_packet_end),
      .sof_crc_bad(sof_crc_bad), .sof_frame_in(sof_frame_in), .host_resume(host_resume),
      .usb_bus_reset(usb_bus_reset), .interrupt_status(interrupt_status),
      .address_state_bit(address_state_bit), .configured_state_bit(configured_state_bit),
      .function_address_value(function_address_value),
      .function_enable_bit(function_enable_bit), .remote_wake_start(remote_wake_start),
      .start_of_frame_irq(start_of_frame_irq), .irq(irq));

   udsir_host_model host (.clock(clock), .sof_packet_id(sof_packet_id),
      .sof_packet_end(sof_packet_end), .sof_crc_bad(sof_crc_bad),
      .sof_frame_in(sof_frame_in), .host_resume(host_resume),
      .usb_bus_reset(usb_bus_reset));

   task stop_test;
      begin
         $display("mismatches %0d comparisons %0d", fail_count, comparisons);
         if (fail_count == 0 && comparisons > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (remote_wake_start === 1'b1) wakes <= wakes + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         stop_test;
      end
   end

   task chk(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask

   // bready stays high throughout, so only the response edge ends a write
   task axw(input [7:0] a, input [31:0] d, input [1:0] er);
      reg ad;
      reg wd;
      begin
         ad = 1'b0;
         wd = 1'b0;
         s_awaddr <= a;
         s_wdata <= d;
         s_awvalid <= 1'b1;
         s_wvalid <= 1'b1;
         while (!(ad && wd)) begin
            @(posedge clock);
            if (!ad && s_awready === 1'b1) begin
               ad = 1'b1;
               s_awvalid <= 1'b0;
            end
            if (!wd && s_wready === 1'b1) begin
               wd = 1'b1;
               s_wvalid <= 1'b0;
            end
         end
         @(posedge clock);
         while (s_bvalid !== 1'b1) @(posedge clock);
         chk(s_bresp, er);
      end
   endtask

   task axr(input [7:0] a, input [31:0] ed, input [1:0] er);
      begin
         s_araddr <= a;
         s_arvalid <= 1'b1;
         @(posedge clock);
         while (s_arready !== 1'b1) @(posedge clock);
         s_arvalid <= 1'b0;
         @(posedge clock);
         while (s_rvalid !== 1'b1) @(posedge clock);
         chk(s_rdata, ed);
         chk(s_rresp, er);
      end
   endtask

   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      axr(8'h00, 32'h0, 2'h0);
      axr(8'h04, 32'h0, 2'h0);
      axr(8'h08, 32'h100, 2'h0);
      axr(8'h18, 32'h1200, 2'h0);
      axr(8'h0C, 32'h0, 2'h2);
      axw(8'h00, 32'hFFFF, 2'h2);
      axw(8'h10, 32'hFFFFFFFF, 2'h0);
      axr(8'h18, 32'h3BFF, 2'h0);
      axw(8'h14, 32'h200, 2'h0);
      axr(8'h18, 32'h39FF, 2'h0);
      axw(8'h14, 32'hFFFF, 2'h0);
      axr(8'h18, 32'h1000, 2'h0);
      axw(8'h10, 32'h800, 2'h0);
      interrupt_status <= 16'h00FF;
      repeat (3) @(posedge clock);
      chk(irq, 0);
      interrupt_status <= 16'h0800;
      repeat (3) @(posedge clock);
      chk(irq, 1);
      interrupt_status <= 16'h1000;
      repeat (3) @(posedge clock);
      interrupt_status <= 16'h0000;
      host.sof(11'h7FF, 1'b0, 2);
      axr(8'h00, 32'h207FF, 2'h0);
      fork
         host.sof(11'h123, 1'b1, 12);
         begin
            repeat (2) @(posedge clock);
            chk(start_of_frame_irq, 1);
            axr(8'h00, 32'h7FF, 2'h0);
         end
      join
      axr(8'h00, 32'h10123, 2'h0);
      axw(8'h08, 32'h17F, 2'h0);
      axr(8'h08, 32'h17F, 2'h0);
      axw(8'h04, 32'h1, 2'h0);
      axw(8'h04, 32'h0, 2'h0);
      axr(8'h04, 32'h1, 2'h0);
      axw(8'h04, 32'h3, 2'h0);
      axr(8'h04, 32'h3, 2'h0);
      axw(8'h04, 32'h1, 2'h0);
      axr(8'h04, 32'h1, 2'h0);
      axw(8'h04, 32'h5, 2'h0);
      axw(8'h04, 32'h1, 2'h0);
      axw(8'h04, 32'h15, 2'h0);
      axw(8'h04, 32'h15, 2'h0);
      repeat (3) @(posedge clock);
      chk(wakes, 1);
      host.pulse(1'b0);
      axr(8'h04, 32'h1D, 2'h0);
      axw(8'h04, 32'h11, 2'h0);
      axr(8'h04, 32'h11, 2'h0);
      axw(8'h08, 32'h05, 2'h0);
      axr(8'h08, 32'h05, 2'h0);
      host.pulse(1'b1);
      axr(8'h04, 32'h0, 2'h0);
      axr(8'h08, 32'h0, 2'h0);
      axw(8'h08, 32'h100, 2'h0);
      axr(8'h08, 32'h100, 2'h0);
      axr(8'h18, 32'h1200, 2'h0);
      stop_test;
   end
endmodule // testbench
